// file: logic/atc_pkg.sv
`default_nettype none
package atc_pkg;

    // vertical trigger modes
    typedef enum logic [2:0] {
        vertical_free_run_mode,
        triggered_command_mode,
        triggered_command_start_stop_mode,
        vertical_one_shot_mode,
        vertical_self_one_shot_mode,
        continuous_source_mode,
        one_shot_start_first_stop_second,
        one_shot_start_stop_same_input
    } atc_vmode_t;

    // line trigger modes
    typedef enum logic [1:0] {
        line_free_run_mode,
        line_one_shot_mode,
        line_self_one_shot_mode
    } atc_hmode_t;

    // polarity: 0 rising, 1 falling
    localparam logic POL_RISING = 1'b0;
    localparam logic POL_FALLING = 1'b1;

    // acquisition commands from host
    typedef enum logic [2:0] {
        cmd_none,
        cmd_snap,
        cmd_grab,
        cmd_freeze,
        cmd_abort
    } atc_cmd_t;

    // configuration carrier
    typedef struct packed {
        atc_vmode_t vmode;
        logic vpol;
        atc_hmode_t hmode;
        logic hpol;
        logic enc_first;
        logic ext_attach;
    } atc_cfg_t;

    // raw trigger level carrier
    typedef struct packed {
        logic sw_first;
        logic sw_second;
        logic hw_first;
        logic hw_second;
    } atc_trig_t;

    localparam int SELF_FRAME_PERIOD = 1000;
    localparam int SELF_LINE_PERIOD = 50;
    localparam int LINES_PER_FRAME = 16;
    localparam logic [15:0] TABLE_RESET_VALUE = 16'h0000;

endpackage : atc_pkg
`default_nettype wire

// file: logic/atc_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser with edge detection after the second flop
module atc_sync_edge (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // async level in
    input wire logic din,
    // synchronised level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_q, s1_d;
    logic s2_q, s2_d;
    logic s3_q, s3_d;

    always_comb
    begin
        s1_d = din;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign level = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule : atc_sync_edge
`default_nettype wire

// file: logic/atc_period_gen.sv
`timescale 1ns/1ps
`default_nettype none
// self trigger generator: one-cycle pulse every PERIOD cycles while enabled
module atc_period_gen #(
    parameter int PERIOD = 1000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // control
    input wire logic en,
    // pulse out
    output logic tick
);
    logic [15:0] cnt_q, cnt_d;

    always_comb
    begin
        cnt_d = cnt_q;
        if (!en)
            cnt_d = 16'h0000;
        else if (cnt_q == 16'(PERIOD - 1))
            cnt_d = 16'h0000;
        else
            cnt_d = cnt_q + 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            cnt_q <= 16'h0000;
        else
            cnt_q <= cnt_d;
    end

    assign tick = en && (cnt_q == 16'(PERIOD - 1));
endmodule : atc_period_gen
`default_nettype wire

// file: logic/atc_trigger_ctrl.sv
//
// Behaviour
// R01: vertical free run: frames acquired continuously, no trigger needed.
// R02: triggered command mode: snap or grab held armed until trigger asserts.
// R03: latched gated command starts capture at next camera frame start.
// R04: gating applies only to snap and grab; freeze and abort act at once.
// R05: start/stop modes generate acquisition commands from triggers themselves.
// R06: host issues acquisition command before trigger in non start/stop modes.
// R07: start first stop second: rise on first starts, rise on second stops.
// R08: start stop same input: rise on first starts, its fall stops.
// R09: frame trigger polarity selects rising or falling edge detection.
// R10: each vertical trigger acquires one frame, or configured lines for line scan.
// R11: external trigger acts only when attached; software triggers always usable.
// R12: line one shot needs a line trigger per line; free run does not.
// R13: one line polarity setting applies to all line triggers.
// R14: with encoder first selected, second encoder input is ignored.
// R15: FIFO reset request clears the data FIFO and freeze register.
// R16: control table reset request returns tables to reset state.
// R17: configured vertical mode and polarity read back from trigger logic.
// R18: triggered command mode may lag trigger by up to one frame.
// R19: report live level of each software and hardware trigger input.
// R20: attach enable connects external trigger; its state is readable.
// R21: self one shot modes generate frame or line triggers internally.
// R22: continuous source mode accepts data continuously without trigger gating.
//
`timescale 1ns/1ps
`default_nettype none
module atc_trigger_ctrl #(
    parameter int LINES = atc_pkg::LINES_PER_FRAME,
    parameter int SELF_FRAME = atc_pkg::SELF_FRAME_PERIOD,
    parameter int SELF_LINE = atc_pkg::SELF_LINE_PERIOD
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // configuration and commands from host
    input wire atc_pkg::atc_cfg_t cfg,
    input wire atc_pkg::atc_cmd_t cmd,
    input wire logic cmd_valid,
    input wire logic fifo_reset_req,
    input wire logic ctab_reset_req,
    // software trigger levels
    input wire logic sw_trig_first,
    input wire logic sw_trig_second,
    // pins from camera and external sources
    input wire logic hw_trig_first,
    input wire logic hw_trig_second,
    input wire logic enc_first,
    input wire logic enc_second,
    input wire logic cam_frame_start,
    input wire logic cam_line_valid,
    // acquisition control
    output logic acq_active,
    output logic frame_capture,
    output logic line_capture,
    output logic cmd_armed,
    output logic frozen,
    output logic fifo_clear,
    output logic ctab_clear,
    output logic [15:0] ctab_value,
    // status readback
    output atc_pkg::atc_cfg_t cfg_readback,
    output atc_pkg::atc_trig_t trig_status
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic hwa_lvl, hwa_rise, hwa_fall;
    logic hwb_lvl, hwb_rise, hwb_fall;
    logic enc_lvl, enc_rise, enc_fall;
    logic fs_lvl, fs_rise;
    logic lv_lvl;

    atc_sync_edge u_hwa (.mclk(mclk), .rst_b(rst_b), .din(hw_trig_first),
        .level(hwa_lvl), .rise(hwa_rise), .fall(hwa_fall));
    atc_sync_edge u_hwb (.mclk(mclk), .rst_b(rst_b), .din(hw_trig_second),
        .level(hwb_lvl), .rise(hwb_rise), .fall(hwb_fall));
    // second encoder input is never synchronised nor used [R14]
    atc_sync_edge u_enc (.mclk(mclk), .rst_b(rst_b), .din(enc_first),
        .level(enc_lvl), .rise(enc_rise), .fall(enc_fall));
    atc_sync_edge u_fs (.mclk(mclk), .rst_b(rst_b), .din(cam_frame_start),
        .level(fs_lvl), .rise(fs_rise), .fall());
    atc_sync_edge u_lv (.mclk(mclk), .rst_b(rst_b), .din(cam_line_valid),
        .level(lv_lvl), .rise(), .fall());

    logic unused_ok;
    assign unused_ok = enc_second ^ fs_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers and software trigger edges
    atc_pkg::atc_cfg_t cfg_q, cfg_d;
    logic swa_q, swa_d, swb_q, swb_d;

    always_comb
    begin
        cfg_d = cfg;
        swa_d = sw_trig_first;
        swb_d = sw_trig_second;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            cfg_q <= '0;
            swa_q <= 1'b0;
            swb_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            swa_q <= swa_d;
            swb_q <= swb_d;
        end
    end

    assign cfg_readback = cfg_q; // [R17] [R20]
    assign trig_status = '{sw_first: sw_trig_first, sw_second: sw_trig_second,
                           hw_first: hwa_lvl, hw_second: hwb_lvl}; // [R19]

    // effective trigger edges: hardware only while attached [R11]
    logic a_rise, a_fall, b_rise;
    always_comb
    begin
        a_rise = (sw_trig_first & ~swa_q) | (cfg_q.ext_attach & hwa_rise); // [R11]
        a_fall = (~sw_trig_first & swa_q) | (cfg_q.ext_attach & hwa_fall);
        b_rise = (sw_trig_second & ~swb_q) | (cfg_q.ext_attach & hwb_rise);
    end

    ////////////////////////////////////////////////////////////////////////////
    // self trigger generators
    logic self_frame_tick, self_line_tick;
    logic self_v_en, self_h_en;
    assign self_v_en = (cfg_q.vmode == atc_pkg::vertical_self_one_shot_mode);
    assign self_h_en = (cfg_q.hmode == atc_pkg::line_self_one_shot_mode);

    atc_period_gen #(.PERIOD(SELF_FRAME)) u_vgen (.mclk(mclk), .rst_b(rst_b),
        .en(self_v_en), .tick(self_frame_tick)); // [R21]
    atc_period_gen #(.PERIOD(SELF_LINE)) u_hgen (.mclk(mclk), .rst_b(rst_b),
        .en(self_h_en), .tick(self_line_tick)); // [R21]

    // vertical trigger with polarity
    logic vtrig;
    always_comb
    begin
        vtrig = (cfg_q.vpol == atc_pkg::POL_RISING) ? a_rise : a_fall; // [R09]
        if (self_v_en)
            vtrig = self_frame_tick; // [R21]
    end

    // line trigger, one polarity for all [R13]
    logic htrig;
    always_comb
    begin
        htrig = (cfg_q.hpol == atc_pkg::POL_RISING) ? enc_rise : enc_fall; // [R13] [R14]
        if (self_h_en)
            htrig = self_line_tick;
    end

    ////////////////////////////////////////////////////////////////////////////
    // acquisition state
    typedef enum logic [1:0] {
        st_idle,
        st_armed,
        st_wait_frame,
        st_run
    } atc_state_t;

    atc_state_t st_q, st_d;
    logic grab_q, grab_d;
    logic frozen_q, frozen_d;
    logic [15:0] lines_q, lines_d;
    logic frame_cap_q, frame_cap_d;
    logic line_cap_q, line_cap_d;
    logic stop_d;

    logic is_ss, gated, snap_grab, line_ok;
    always_comb
    begin
        is_ss = (cfg_q.vmode == atc_pkg::triggered_command_start_stop_mode) ||
                (cfg_q.vmode == atc_pkg::one_shot_start_first_stop_second) ||
                (cfg_q.vmode == atc_pkg::one_shot_start_stop_same_input);
        gated = (cfg_q.vmode == atc_pkg::triggered_command_mode) ||
                (cfg_q.vmode == atc_pkg::vertical_one_shot_mode) ||
                (cfg_q.vmode == atc_pkg::vertical_self_one_shot_mode);
        snap_grab = cmd_valid && (cmd == atc_pkg::cmd_snap || cmd == atc_pkg::cmd_grab);
        // line one shot: capture only on a line trigger [R12]
        line_ok = (cfg_q.hmode == atc_pkg::line_free_run_mode) ? lv_lvl : htrig; // [R12]
    end

    always_comb
    begin
        st_d = st_q;
        grab_d = grab_q;
        frozen_d = frozen_q;
        lines_d = lines_q;
        stop_d = 1'b0;
        frame_cap_d = 1'b0;
        line_cap_d = 1'b0;
        if (cfg_q.vmode == atc_pkg::vertical_free_run_mode ||
            cfg_q.vmode == atc_pkg::continuous_source_mode)
        begin
            // no trigger gating at all [R01] [R22]
            if (st_q == st_idle)
                st_d = (cfg_q.vmode == atc_pkg::continuous_source_mode) ? st_run : st_wait_frame; // [R22]
            grab_d = 1'b1; // [R01]
        end
        else if (is_ss)
        begin
            // hardware issues the commands [R05]
            unique case (cfg_q.vmode)
                atc_pkg::one_shot_start_first_stop_second:
                begin
                    if (a_rise)
                        st_d = st_wait_frame; // [R07]
                    if (b_rise)
                        stop_d = 1'b1; // [R07]
                end
                atc_pkg::one_shot_start_stop_same_input:
                begin
                    if (a_rise)
                        st_d = st_wait_frame; // [R08]
                    if (a_fall)
                        stop_d = 1'b1; // [R08]
                end
                default:
                begin
                    if (vtrig && st_q == st_idle)
                        st_d = st_wait_frame; // [R05]
                    else if (vtrig)
                        stop_d = 1'b1;
                end
            endcase
            grab_d = 1'b1;
            // a stop edge while idle is dropped, never held over to the next start
            if (stop_d && st_q != st_idle)
                st_d = st_idle;
        end
        else
        begin
            // host commands gated by trigger [R02] [R06]
            if (snap_grab && st_q == st_idle)
            begin
                st_d = st_armed; // [R02]
                grab_d = (cmd == atc_pkg::cmd_grab);
            end
            if (st_q == st_armed && vtrig)
                st_d = st_wait_frame; // [R02] [R18]
        end
        // next frame start begins capture [R03]
        if (st_q == st_wait_frame && fs_rise)
        begin
            st_d = st_run; // [R03]
            frame_cap_d = 1'b1;
            lines_d = 16'h0000;
        end
        if (st_q == st_run && line_ok && cfg_q.vmode != atc_pkg::continuous_source_mode)
        begin
            line_cap_d = 1'b1;
            lines_d = lines_q + 16'h0001;
            // one frame of LINES per vertical trigger [R10]
            if (lines_q == 16'(LINES - 1))
            begin
                lines_d = 16'h0000;
                if (grab_q && !gated)
                    st_d = st_wait_frame;
                else if (grab_q)
                    st_d = st_armed;
                else
                    st_d = st_idle; // [R10]
            end
        end
        if (st_q == st_run && cfg_q.vmode == atc_pkg::continuous_source_mode)
            line_cap_d = lv_lvl; // [R22]
        // freeze and abort ungated [R04]
        if (cmd_valid && cmd == atc_pkg::cmd_abort)
        begin
            st_d = st_idle; // [R04]
            grab_d = 1'b0;
        end
        if (cmd_valid && cmd == atc_pkg::cmd_freeze)
        begin
            frozen_d = 1'b1; // [R04]
            grab_d = 1'b0;
        end
        if (fifo_reset_req)
            frozen_d = 1'b0; // [R15]
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            st_q <= st_idle;
            grab_q <= 1'b0;
            frozen_q <= 1'b0;
            lines_q <= 16'h0000;
            frame_cap_q <= 1'b0;
            line_cap_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            grab_q <= grab_d;
            frozen_q <= frozen_d;
            lines_q <= lines_d;
            frame_cap_q <= frame_cap_d;
            line_cap_q <= line_cap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fifo and control table resets
    logic fclr_q, fclr_d, cclr_q, cclr_d;
    logic [15:0] ctab_q, ctab_d;

    always_comb
    begin
        fclr_d = fifo_reset_req; // [R15]
        cclr_d = ctab_reset_req; // [R16]
        ctab_d = ctab_q;
        if (ctab_reset_req)
            ctab_d = atc_pkg::TABLE_RESET_VALUE; // [R16]
        else if (frame_cap_q)
            ctab_d = ctab_q + 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            fclr_q <= 1'b0;
            cclr_q <= 1'b0;
            ctab_q <= atc_pkg::TABLE_RESET_VALUE;
        end
        else
        begin
            fclr_q <= fclr_d;
            cclr_q <= cclr_d;
            ctab_q <= ctab_d;
        end
    end

    assign acq_active = (st_q == st_run);
    assign frame_capture = frame_cap_q;
    assign line_capture = line_cap_q;
    assign cmd_armed = (st_q == st_armed);
    assign frozen = frozen_q;
    assign fifo_clear = fclr_q;
    assign ctab_clear = cclr_q;
    assign ctab_value = ctab_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_armed_trig;
        (st_q == st_armed) && vtrig && !(cmd_valid && cmd == atc_pkg::cmd_abort);
    endsequence

    a_armed_holds: assert property (@(posedge mclk) disable iff (!rst_b) // [R02]
        (st_q == st_armed && !vtrig && !cmd_valid && cfg_q.vmode == cfg.vmode &&
         cfg_q.vmode == atc_pkg::triggered_command_mode) |=> (st_q == st_armed))
        else $error("armed command latched without trigger");
    a_trig_latches: assert property (@(posedge mclk) disable iff (!rst_b) // [R02]
        s_armed_trig |=> (st_q == st_wait_frame) || (st_q == st_run))
        else $error("trigger did not latch command");
    a_frame_start: assert property (@(posedge mclk) disable iff (!rst_b) // [R03]
        (st_q == st_wait_frame && fs_rise && !cmd_valid) |=> frame_capture && acq_active)
        else $error("capture did not start at frame start");
    a_abort_now: assert property (@(posedge mclk) disable iff (!rst_b) // [R04]
        (cmd_valid && cmd == atc_pkg::cmd_abort) |=> !acq_active)
        else $error("abort not immediate");
    a_freeze_now: assert property (@(posedge mclk) disable iff (!rst_b) // [R04]
        (cmd_valid && cmd == atc_pkg::cmd_freeze && !fifo_reset_req) |=> frozen)
        else $error("freeze not immediate");
    a_fifo_clear: assert property (@(posedge mclk) disable iff (!rst_b) // [R15]
        fifo_reset_req |=> fifo_clear && !frozen)
        else $error("fifo reset did not clear freeze");
    a_ctab_clear: assert property (@(posedge mclk) disable iff (!rst_b) // [R16]
        ctab_reset_req |=> ctab_clear && (ctab_value == atc_pkg::TABLE_RESET_VALUE))
        else $error("control table not reset");
    a_ext_detach: assert property (@(posedge mclk) disable iff (!rst_b) // [R11]
        (!cfg_q.ext_attach && !sw_trig_first && !swa_q) |-> !a_rise && !a_fall)
        else $error("detached external trigger acted");
    a_readback: assert property (@(posedge mclk) disable iff (!rst_b) // [R17]
        1'b1 |=> cfg_readback == $past(cfg))
        else $error("mode readback mismatch");
    a_ss_start: assert property (@(posedge mclk) disable iff (!rst_b) // [R07]
        (cfg_q.vmode == atc_pkg::one_shot_start_first_stop_second && st_q == st_idle &&
         a_rise && !b_rise && !cmd_valid) |=> st_q == st_wait_frame)
        else $error("start edge ignored");
endmodule : atc_trigger_ctrl
`default_nettype wire

// file: test/atc_cam_model.sv
`timescale 1ns/1ps
`default_nettype none
// camera and encoder pins; each frame_go from the bench restarts frame timing, triggers never reset it
module atc_cam_model (
    // clock
    input wire logic mclk,
    // frame request from bench
    input wire logic frame_go,
    // camera and encoder pins
    output logic cam_frame_start,
    output logic cam_line_valid,
    output logic enc_first,
    output logic enc_second
);
    int cnt = 99;
    initial enc_second = 1'b0;
    ////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        cnt <= frame_go ? 0 : (cnt < 99 ? cnt + 1 : cnt);
        enc_second <= ~enc_second; // noise on the input that must be ignored
    end
    always_comb
    begin
        cam_frame_start = cnt < 4;
        cam_line_valid = cnt >= 6 && cnt < 26;
        enc_first = cam_line_valid && cnt[0];
    end
endmodule : atc_cam_model
`default_nettype wire

// file: test/test_acquisition_trigger_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_acquisition_trigger_control;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    atc_pkg::atc_cfg_t cfg = '0;
    atc_pkg::atc_cmd_t cmd = atc_pkg::cmd_none;
    logic cmd_valid = 1'b0;
    logic fifo_reset_req = 1'b0;
    logic ctab_reset_req = 1'b0;
    logic sw_trig_first = 1'b0;
    logic sw_trig_second = 1'b0;
    logic hw_trig_first = 1'b0;
    logic hw_trig_second = 1'b0;
    logic frame_go = 1'b0;
    logic enc_first, enc_second, cam_frame_start, cam_line_valid;
    logic acq_active, frame_capture, line_capture, cmd_armed, frozen, fifo_clear, ctab_clear;
    logic [15:0] ctab_value;
    atc_pkg::atc_cfg_t cfg_readback;
    atc_pkg::atc_trig_t trig_status;
    logic [1:0] exp_q[$];
    int n_errors = 0;
    int n_checks = 0;
    int n_lines = 0;
    int k;
    ////////////////////////////////////////////////////////////
    atc_trigger_ctrl #(.SELF_FRAME(10), .SELF_LINE(4)) dut_u (.mclk, .rst_b, .cfg, .cmd, .cmd_valid,
        .fifo_reset_req, .ctab_reset_req, .sw_trig_first, .sw_trig_second, .hw_trig_first,
        .hw_trig_second, .enc_first, .enc_second, .cam_frame_start, .cam_line_valid, .acq_active,
        .frame_capture, .line_capture, .cmd_armed, .frozen, .fifo_clear, .ctab_clear, .ctab_value,
        .cfg_readback, .trig_status);
    atc_cam_model cam_u (.mclk, .frame_go, .cam_frame_start, .cam_line_valid, .enc_first, .enc_second);
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask : tick
    task automatic host(input atc_pkg::atc_cmd_t c);
        cmd = c;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
        tick(1);
    endtask : host
    // event codes: 1 frame capture, 2 fifo clear, 3 table clear
    task automatic pulse_frame(input logic expect_cap);
        if (expect_cap)
            exp_q.push_back(2'd1);
        frame_go = 1'b1;
        tick(1);
        frame_go = 1'b0;
        tick(30);
    endtask : pulse_frame
    task automatic set_mode(input atc_pkg::atc_vmode_t m, input logic pol);
        // mode first, so the abort lands in the new mode and leaves gated and start/stop modes idle
        cfg.vmode = m;
        cfg.vpol = pol;
        tick(2);
        host(atc_pkg::cmd_abort);
    endtask : set_mode
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        #2;
        if (line_capture === 1'b1)
            n_lines++;
        if ((frame_capture | fifo_clear | ctab_clear) === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("unexpected event", 32'd1, 32'd0);
            else
                chk("event kind", 32'({fifo_clear | ctab_clear, frame_capture | ctab_clear}),
                    32'(exp_q.pop_front()));
        end
    end
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'hacffc237));
        tick(20);
        rst_b = 1'b1;
        chk("reset readback", 32'(cfg_readback), 32'd0);
        for (k = 0; k < 4; k++)
        begin
            {sw_trig_first, sw_trig_second, hw_trig_first, hw_trig_second} = 4'($urandom);
            tick(4);
            chk("trigger levels", 32'(trig_status),
                32'({sw_trig_first, sw_trig_second, hw_trig_first, hw_trig_second}));
        end
        {sw_trig_first, sw_trig_second, hw_trig_first, hw_trig_second} = 4'd0;
        for (k = 0; k < 8; k++)
        begin
            cfg = 9'($urandom);
            cfg.vmode = atc_pkg::atc_vmode_t'(k);
            cfg.hmode = atc_pkg::line_free_run_mode;
            tick(2);
            chk("cfg readback", 32'(cfg_readback), 32'(cfg));
        end
        cfg = '0;
        for (k = 0; k < 3; k++)
        begin
            cfg.hmode = k ? atc_pkg::line_one_shot_mode : atc_pkg::line_free_run_mode;
            cfg.hpol = k[1];
            set_mode(atc_pkg::vertical_free_run_mode, 1'b0);
            n_lines = 0;
            pulse_frame(1'b1);
            // model gives ten encoder pulses per frame
            chk("lines per frame", 32'(n_lines), k ? 32'd10 : 32'(atc_pkg::LINES_PER_FRAME));
        end
        cfg.hmode = atc_pkg::line_free_run_mode;
        set_mode(atc_pkg::continuous_source_mode, 1'b0);
        n_lines = 0;
        pulse_frame(1'b0);
        chk("continuous lines", 32'(n_lines), 32'd20);
        for (k = 0; k < 2; k++)
        begin
            set_mode(atc_pkg::triggered_command_mode, k[0]);
            sw_trig_first = ~k[0];
            tick(3);
            host(atc_pkg::cmd_snap);
            chk("armed", 32'(cmd_armed), 32'd1);
            pulse_frame(1'b0);
            chk("armed after frame", 32'(cmd_armed), 32'd1);
            sw_trig_first = k[0];
            tick(5);
            chk("armed on idle edge", 32'(cmd_armed), 32'd1);
            sw_trig_first = ~k[0];
            tick(3);
            chk("latched", 32'(cmd_armed), 32'd0);
            pulse_frame(1'b1);
        end
        host(atc_pkg::cmd_snap);
        host(atc_pkg::cmd_freeze);
        chk("frozen", 32'(frozen), 32'd1);
        host(atc_pkg::cmd_abort);
        chk("aborted", 32'(cmd_armed), 32'd0);
        exp_q.push_back(2'd2);
        fifo_reset_req = 1'b1;
        tick(1);
        fifo_reset_req = 1'b0;
        tick(2);
        chk("freeze cleared", 32'(frozen), 32'd0);
        exp_q.push_back(2'd3);
        ctab_reset_req = 1'b1;
        tick(1);
        ctab_reset_req = 1'b0;
        tick(2);
        chk("table value", 32'(ctab_value), 32'(atc_pkg::TABLE_RESET_VALUE));
        for (k = 0; k < 2; k++)
        begin
            cfg.ext_attach = k[0];
            set_mode(atc_pkg::vertical_one_shot_mode, 1'b0);
            host(atc_pkg::cmd_snap);
            hw_trig_first = 1'b1;
            tick(6);
            chk("hw trigger gate", 32'(cmd_armed), 32'(1 - k));
            hw_trig_first = 1'b0;
            tick(4);
        end
        set_mode(atc_pkg::vertical_self_one_shot_mode, 1'b0);
        host(atc_pkg::cmd_snap);
        tick(15);
        chk("self trigger", 32'(cmd_armed), 32'd0);
        pulse_frame(1'b1);
        for (k = 0; k < 3; k++)
        begin
            set_mode(k == 2 ? atc_pkg::triggered_command_start_stop_mode :
                (k ? atc_pkg::one_shot_start_stop_same_input : atc_pkg::one_shot_start_first_stop_second), 1'b0);
            sw_trig_first = 1'b1;
            tick(2);
            exp_q.push_back(2'd1);
            frame_go = 1'b1;
            tick(1);
            frame_go = 1'b0;
            tick(10);
            chk("run started", 32'(acq_active), 32'd1);
            if (k == 2)
                hw_trig_first = 1'b1;
            else if (k)
                sw_trig_first = 1'b0;
            else
                sw_trig_second = 1'b1;
            for (int i = 0; i < 40 && acq_active !== 1'b0; i++)
                tick(1);
            chk("run stopped", 32'(acq_active), 32'd0);
            sw_trig_first = 1'b0;
            sw_trig_second = 1'b0;
            hw_trig_first = 1'b0;
            pulse_frame(1'b0);
        end
        tick(5);
        chk("pending events", 32'(exp_q.size()), 32'd0);
        complete_run();
    end
endmodule : test_acquisition_trigger_control
`default_nettype wire
